// [hdl/iad_consts.svh]
// Constants of the integer ALU datapath
// Assumes inclusion by bare name from design files
`ifndef IAD_CONSTS_SVH
`define IAD_CONSTS_SVH
// APB register offsets
`define IAD_OFF_CTRL 12'h000
`define IAD_OFF_FLAGS 12'h004
`define IAD_OFF_STATUS 12'h008
`define IAD_OFF_Y 12'h00c
// Field positions
`define IAD_CTRL_HOLD 0
`define IAD_STS_BUSY 0
`define IAD_STS_DIV0 1
`define IAD_STS_TAG 2
`define IAD_FLG_N 3
`define IAD_FLG_Z 2
`define IAD_FLG_V 1
`define IAD_FLG_C 0
// Reset values and timing
`define IAD_FLAGS_RST 4'h0
`define IAD_DIV_STEPS 7'h40
`endif

// [hdl/iad_pkg.sv]
// Types of the integer ALU datapath
// Assumes nothing beyond a SystemVerilog compiler
package iad_pkg;
    typedef enum logic [4:0] {
        op_add = 5'h00, op_sub = 5'h01, op_and = 5'h02, op_or = 5'h03,
        op_xor = 5'h04, op_sll = 5'h05, op_srl = 5'h06, op_sra = 5'h07,
        set_high_constant_op = 5'h08, op_mulx = 5'h09, op_sdivx = 5'h0a,
        op_udivx = 5'h0b, op_umul = 5'h0c, op_smul = 5'h0d, op_udiv = 5'h0e,
        op_sdiv = 5'h0f, op_mulstep = 5'h10, tagged_add_flags_op = 5'h11,
        tagged_sub_flags_op = 5'h12, tagged_add_trapping_op = 5'h13,
        tagged_sub_trapping_op = 5'h14
    } iad_op_e;
    typedef enum logic [1:0] {st_idle = 2'h1, st_div = 2'h2} iad_state_e;
endpackage

// [hdl/iad_flag_gen.sv]
// Condition flag generator for one width
// Assumes operands and result of one add, subtract or logic step
`timescale 1ns/1ps
`include "iad_consts.svh"
module iad_flag_gen #(parameter int W = 32) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    input wire logic [W-1:0] res,
    input wire logic sub,
    input wire logic arith,
    output logic [3:0] nzvc
);
    logic [W:0] carry_sum;
    // Carry out of the add, borrow of the subtract
    always_comb begin
        carry_sum = {1'b0, a} + {1'b0, b};
        nzvc[`IAD_FLG_N] = res[W-1];
        nzvc[`IAD_FLG_Z] = (res == '0);
        nzvc[`IAD_FLG_V] = 1'b0;
        nzvc[`IAD_FLG_C] = 1'b0;
        if (arith && sub) begin
            nzvc[`IAD_FLG_V] = (a[W-1] != b[W-1]) && (res[W-1] != a[W-1]);
            nzvc[`IAD_FLG_C] = (a < b);
        end else if (arith) begin
            nzvc[`IAD_FLG_V] = (a[W-1] == b[W-1]) && (res[W-1] != a[W-1]);
            nzvc[`IAD_FLG_C] = carry_sum[W];
        end
    end
endmodule // iad_flag_gen

// [hdl/iad_divider.sv]
// Iterative unsigned 64 by 64 divider, one quotient bit a cycle
// Assumes divisor nonzero at start; start only while not busy
`timescale 1ns/1ps
`include "iad_consts.svh"
module iad_divider (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [63:0] dividend,
    input wire logic [63:0] divisor,
    output logic done,
    output logic [63:0] quotient
);
    typedef struct packed {
        logic [6:0] count;
        logic [64:0] rem;
        logic [63:0] quo;
        logic [63:0] dsr;
        logic done;
    } iad_div_s;
    iad_div_s r, next_r;
    logic [64:0] shifted;
    // One restoring step per cycle while counting
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        shifted = {r.rem[63:0], r.quo[63]};
        if (start) begin
            next_r.count = `IAD_DIV_STEPS;
            next_r.rem = '0;
            next_r.quo = dividend;
            next_r.dsr = divisor;
        end else if (r.count != 7'h00) begin
            next_r.count = r.count - 7'h01;
            next_r.done = (r.count == 7'h01);
            if (shifted >= {1'b0, r.dsr}) begin
                next_r.rem = shifted - {1'b0, r.dsr};
                next_r.quo = {r.quo[62:0], 1'b1};
            end else begin
                next_r.rem = shifted;
                next_r.quo = {r.quo[62:0], 1'b0};
            end
        end
    end
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign done = r.done;
    assign quotient = r.quo;
endmodule // iad_divider

// [hdl/iad_core.sv]
// Integer execute datapath: operands, ALU, multiply, divide, flags
// Assumes decode logic issues one operation at a time on pclk
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "iad_consts.svh"
module iad_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic issue_valid,
    output logic issue_ready,
    input wire iad_pkg::iad_op_e issue_op,
    input wire logic issue_set_cc,
    input wire logic issue_use_imm,
    input wire logic [4:0] src_a_reg,
    input wire logic [4:0] src_b_reg,
    input wire logic [4:0] dst_reg,
    input wire logic [12:0] short_const_13,
    input wire logic [21:0] set_const_22,
    input wire logic load_valid,
    input wire logic [4:0] load_idx,
    input wire logic [63:0] load_data,
    output logic result_valid,
    output logic [63:0] result_data,
    output logic [4:0] result_dst,
    output logic divide_zero_trap,
    output logic tag_overflow_trap,
    output logic [3:0] low_word_flags,
    output logic [3:0] full_width_flags
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        iad_pkg::iad_state_e state;
        logic [31:0][63:0] regs;
        logic [3:0] low_flags;
        logic [3:0] full_flags;
        logic [31:0] y;
        logic hold;
        logic sts_div0;
        logic sts_tag;
        logic res_valid;
        logic [63:0] res_data;
        logic [4:0] res_dst;
        logic div0_pulse;
        logic tag_pulse;
        logic [31:0] prdata;
        logic pslverr;
        iad_pkg::iad_op_e div_op;
        logic div_neg;
        logic div_cc;
        logic [4:0] div_dst;
    } iad_core_s;
    iad_core_s r, next_r;

    logic fire, is_div, is_legacy_div, is_signed_div, div_zero, div_done;
    logic is_tagged, is_trap_tag, tag_bad, tag_ovf, upd_cc, ar_sub, ar_arith;
    logic [63:0] op_a, op_b, res_comb, ar_a, ar_b, dsr_full, dvd_abs, dsr_abs;
    logic [63:0] quot, div_q;
    logic [3:0] low_raw, full_raw, low_new;
    logic [31:0] rd_mux;
    logic rd_hit;

    // ****************************************
    // Operand selection
    // ****************************************
    // Register zero is forced to zero on read
    always_comb begin
        op_a = (src_a_reg == 5'h00) ? 64'h0 : r.regs[src_a_reg];
        if (issue_use_imm) begin
            op_b = {{51{short_const_13[12]}}, short_const_13};
        end else begin
            op_b = (src_b_reg == 5'h00) ? 64'h0 : r.regs[src_b_reg];
        end
    end

    assign issue_ready = (r.state == iad_pkg::st_idle) && !r.hold;
    assign fire = issue_valid && issue_ready;

    // ****************************************
    // Divide control
    // ****************************************
    // Divisor width and sign handling for native and legacy divides
    always_comb begin
        is_legacy_div = (issue_op == iad_pkg::op_udiv) || (issue_op == iad_pkg::op_sdiv);
        is_signed_div = (issue_op == iad_pkg::op_sdivx) || (issue_op == iad_pkg::op_sdiv);
        is_div = is_legacy_div || is_signed_div || (issue_op == iad_pkg::op_udivx);
        if (issue_op == iad_pkg::op_sdiv) begin
            dsr_full = {{32{op_b[31]}}, op_b[31:0]};
        end else if (issue_op == iad_pkg::op_udiv) begin
            dsr_full = {32'h0, op_b[31:0]};
        end else begin
            dsr_full = op_b;
        end
        div_zero = (dsr_full == 64'h0);
        dvd_abs = (is_signed_div && op_a[63]) ? 64'h0 - op_a : op_a;
        dsr_abs = (is_signed_div && dsr_full[63]) ? 64'h0 - dsr_full : dsr_full;
        div_q = r.div_neg ? 64'h0 - quot : quot;
        if (r.div_op == iad_pkg::op_sdiv) begin
            div_q = {{32{div_q[31]}}, div_q[31:0]};
        end else if (r.div_op == iad_pkg::op_udiv) begin
            div_q = {32'h0, div_q[31:0]};
        end
    end

    iad_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .start(fire && is_div && !div_zero),
        .dividend(dvd_abs),
        .divisor(dsr_abs),
        .done(div_done),
        .quotient(quot)
    );

    // ****************************************
    // Arithmetic and logic
    // ****************************************
    // Result and flag inputs for the operation now completing
    always_comb begin
        ar_a = op_a;
        ar_b = op_b;
        ar_sub = 1'b0;
        ar_arith = 1'b0;
        res_comb = 64'h0;
        is_tagged = 1'b0;
        upd_cc = issue_set_cc;
        case (issue_op)
            iad_pkg::op_add: begin
                res_comb = op_a + op_b;
                ar_arith = 1'b1;
            end
            iad_pkg::op_sub: begin
                res_comb = op_a - op_b;
                ar_arith = 1'b1;
                ar_sub = 1'b1;
            end
            iad_pkg::op_and: res_comb = op_a & op_b;
            iad_pkg::op_or: res_comb = op_a | op_b;
            iad_pkg::op_xor: res_comb = op_a ^ op_b;
            iad_pkg::op_sll: begin
                res_comb = op_a << op_b[5:0];
                upd_cc = 1'b0;
            end
            iad_pkg::op_srl: begin
                res_comb = op_a >> op_b[5:0];
                upd_cc = 1'b0;
            end
            iad_pkg::op_sra: begin
                res_comb = 64'($signed(op_a) >>> op_b[5:0]);
                upd_cc = 1'b0;
            end
            iad_pkg::set_high_constant_op: begin
                res_comb = {32'h0, set_const_22, 10'h000};
                upd_cc = 1'b0;
            end
            iad_pkg::op_mulx: res_comb = op_a * op_b;
            iad_pkg::op_umul: res_comb = {32'h0, op_a[31:0]} * {32'h0, op_b[31:0]};
            iad_pkg::op_smul: begin
                res_comb = 64'($signed({{32{op_a[31]}}, op_a[31:0]})
                    * $signed({{32{op_b[31]}}, op_b[31:0]}));
            end
            iad_pkg::op_mulstep: begin
                ar_a = {32'h0, r.low_flags[`IAD_FLG_N] ^ r.low_flags[`IAD_FLG_V], op_a[31:1]};
                ar_b = r.y[0] ? {32'h0, op_b[31:0]} : 64'h0;
                res_comb = {32'h0, ar_a[31:0] + ar_b[31:0]};
                ar_arith = 1'b1;
                upd_cc = 1'b1;
            end
            iad_pkg::tagged_add_flags_op, iad_pkg::tagged_add_trapping_op: begin
                res_comb = op_a + op_b;
                ar_arith = 1'b1;
                is_tagged = 1'b1;
                upd_cc = 1'b1;
            end
            iad_pkg::tagged_sub_flags_op, iad_pkg::tagged_sub_trapping_op: begin
                res_comb = op_a - op_b;
                ar_arith = 1'b1;
                ar_sub = 1'b1;
                is_tagged = 1'b1;
                upd_cc = 1'b1;
            end
            default: res_comb = 64'h0;
        endcase
        if (r.state == iad_pkg::st_div) begin
            res_comb = div_q;
            ar_arith = 1'b0;
            upd_cc = r.div_cc;
        end
    end

    // Low-word and full-width flag sets
    iad_flag_gen #(.W(32)) u_low (
        .a(ar_a[31:0]),
        .b(ar_b[31:0]),
        .res(res_comb[31:0]),
        .sub(ar_sub),
        .arith(ar_arith),
        .nzvc(low_raw)
    );
    iad_flag_gen #(.W(64)) u_full (
        .a(ar_a),
        .b(ar_b),
        .res(res_comb),
        .sub(ar_sub),
        .arith(ar_arith),
        .nzvc(full_raw)
    );

    // Tag check on both operands
    always_comb begin
        is_trap_tag = (issue_op == iad_pkg::tagged_add_trapping_op)
            || (issue_op == iad_pkg::tagged_sub_trapping_op);
        tag_bad = (op_a[1:0] != 2'h0) || (op_b[1:0] != 2'h0);
        tag_ovf = tag_bad || low_raw[`IAD_FLG_V];
        low_new = low_raw;
        if (is_tagged) begin
            low_new[`IAD_FLG_V] = tag_ovf;
        end
    end

    // ****************************************
    // Register read mux
    // ****************************************
    always_comb begin
        rd_hit = 1'b1;
        case (paddr)
            `IAD_OFF_CTRL: rd_mux = {31'h0, r.hold};
            `IAD_OFF_FLAGS: rd_mux = {24'h0, r.full_flags, r.low_flags};
            `IAD_OFF_STATUS: rd_mux = {29'h0, r.sts_tag, r.sts_div0,
                r.state == iad_pkg::st_div};
            `IAD_OFF_Y: rd_mux = r.y;
            default: begin
                rd_mux = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_r = r;
        next_r.res_valid = 1'b0;
        next_r.div0_pulse = 1'b0;
        next_r.tag_pulse = 1'b0;
        // Read data latched in the setup phase
        if (psel && !penable) begin
            next_r.prdata = rd_mux;
            next_r.pslverr = !rd_hit;
        end
        // Software writes before hardware so hardware sets win
        if (psel && penable && pwrite) begin
            case (paddr)
                `IAD_OFF_CTRL: next_r.hold = pwdata[`IAD_CTRL_HOLD];
                `IAD_OFF_FLAGS: begin
                    next_r.low_flags = pwdata[3:0];
                    next_r.full_flags = pwdata[7:4];
                end
                `IAD_OFF_STATUS: begin
                    if (pwdata[`IAD_STS_DIV0]) next_r.sts_div0 = 1'b0;
                    if (pwdata[`IAD_STS_TAG]) next_r.sts_tag = 1'b0;
                end
                `IAD_OFF_Y: next_r.y = pwdata;
                default: next_r.hold = r.hold;
            endcase
        end
        if (load_valid) begin
            next_r.regs[load_idx] = load_data;
        end
        case (r.state)
            iad_pkg::st_idle: begin
                if (fire && is_div && div_zero) begin
                    next_r.div0_pulse = 1'b1;
                    next_r.sts_div0 = 1'b1;
                end else if (fire && is_div) begin
                    next_r.state = iad_pkg::st_div;
                    next_r.div_op = issue_op;
                    next_r.div_neg = is_signed_div && (op_a[63] ^ dsr_full[63]);
                    next_r.div_cc = issue_set_cc;
                    next_r.div_dst = dst_reg;
                end else if (fire && is_trap_tag && tag_ovf) begin
                    next_r.tag_pulse = 1'b1;
                    next_r.sts_tag = 1'b1;
                end else if (fire) begin
                    next_r.res_valid = 1'b1;
                    next_r.res_data = res_comb;
                    next_r.res_dst = dst_reg;
                    next_r.regs[dst_reg] = res_comb;
                    if (upd_cc) begin
                        next_r.low_flags = low_new;
                        next_r.full_flags = full_raw;
                    end
                    if (issue_op == iad_pkg::op_mulstep) begin
                        next_r.y = {op_a[0], r.y[31:1]};
                    end
                end
            end
            iad_pkg::st_div: begin
                if (div_done) begin
                    next_r.state = iad_pkg::st_idle;
                    next_r.res_valid = 1'b1;
                    next_r.res_data = res_comb;
                    next_r.res_dst = r.div_dst;
                    next_r.regs[r.div_dst] = res_comb;
                    if (upd_cc) begin
                        next_r.low_flags = low_raw;
                        next_r.full_flags = full_raw;
                    end
                end
            end
            default: next_r.state = iad_pkg::st_idle;
        endcase
        next_r.regs[0] = 64'h0;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.state <= iad_pkg::st_idle;
            r.low_flags <= `IAD_FLAGS_RST;
            r.full_flags <= `IAD_FLAGS_RST;
        end else begin
            r <= next_r;
        end
    end

    // Outputs
    assign prdata = r.prdata;
    assign pready = 1'b1;
    assign pslverr = r.pslverr;
    assign result_valid = r.res_valid;
    assign result_data = r.res_data;
    assign result_dst = r.res_dst;
    assign divide_zero_trap = r.div0_pulse;
    assign tag_overflow_trap = r.tag_pulse;
    assign low_word_flags = r.low_flags;
    assign full_width_flags = r.full_flags;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_imm_zero;
        fire && issue_use_imm && issue_op == iad_pkg::op_add && src_a_reg == 5'h00
            |=> result_valid && result_data == {{51{$past(short_const_13[12])}},
            $past(short_const_13)};
    endproperty
    a_imm_zero: assert property (p_imm_zero) else $error("imm operand wrong");
    property p_wb;
        result_valid |-> r.regs[result_dst] == (result_dst == 5'h00 ? 64'h0 : result_data);
    endproperty
    a_wb: assert property (p_wb) else $error("writeback mismatch");
    property p_r0;
        r.regs[0] == 64'h0;
    endproperty
    a_r0: assert property (p_r0) else $error("register zero changed");
    property p_nocc;
        fire && !issue_set_cc && !is_div && !is_tagged && issue_op != iad_pkg::op_mulstep
            |=> $stable(low_word_flags) && $stable(full_width_flags);
    endproperty
    a_nocc: assert property (p_nocc) else $error("flags changed");
    property p_shift;
        fire && issue_op inside {iad_pkg::op_sll, iad_pkg::op_srl, iad_pkg::op_sra}
            |=> $stable(low_word_flags) && $stable(full_width_flags);
    endproperty
    a_shift: assert property (p_shift) else $error("shift changed flags");
    property p_set_high_constant_op;
        fire && issue_op == iad_pkg::set_high_constant_op
            |=> result_data == {32'h0, $past(set_const_22), 10'h000} && $stable(low_word_flags);
    endproperty
    a_set_high_constant_op: assert property (p_set_high_constant_op) else $error("high constant wrong");
    property p_div;
        fire && is_div && !div_zero |-> ##[66:67] result_valid;
    endproperty
    a_div: assert property (p_div) else $error("divide late");
    property p_div0;
        fire && is_div && div_zero |=> divide_zero_trap && !result_valid;
    endproperty
    a_div0: assert property (p_div0) else $error("no divide trap");
    property p_tag;
        fire && issue_op == iad_pkg::tagged_add_flags_op && tag_bad
            |=> low_word_flags[`IAD_FLG_V];
    endproperty
    a_tag: assert property (p_tag) else $error("tag overflow missed");
    property p_xv;
        fire && issue_op == iad_pkg::tagged_add_flags_op && op_a[63] == op_b[63]
            |=> full_width_flags[`IAD_FLG_V] == (result_data[63] != $past(op_a[63]));
    endproperty
    a_xv: assert property (p_xv) else $error("full overflow wrong");
    c_div: cover property (fire && is_div && !div_zero);
    c_div0: cover property (divide_zero_trap);
    c_tag: cover property (tag_overflow_trap);
    c_set_high_constant_op: cover property (fire && issue_op == iad_pkg::set_high_constant_op);
endmodule // iad_core

// [test/iad_decode_model.sv]
// Stand-in for the decode stage and register file feeding the datapath
// Assumes one testbench process calls its tasks, one at a time
`timescale 1ns/1ps
module iad_decode_model (
    input wire logic pclk,
    input wire logic issue_ready,
    output iad_pkg::iad_op_e issue_op,
    output logic issue_valid,
    output logic issue_set_cc,
    output logic issue_use_imm,
    output logic [4:0] src_a_reg,
    output logic [4:0] src_b_reg,
    output logic [4:0] dst_reg,
    output logic [12:0] short_const_13,
    output logic [21:0] set_const_22,
    output logic load_valid,
    output logic [4:0] load_idx,
    output logic [63:0] load_data
);
    // Quiet bus at time zero
    initial begin
        issue_op = iad_pkg::op_add;
        {issue_valid, issue_set_cc, issue_use_imm, load_valid} = 4'h0;
        {src_a_reg, src_b_reg, dst_reg, load_idx} = 20'h0;
        {short_const_13, set_const_22, load_data} = 99'h0;
    end

    // Seed one register, one cycle wide
    task automatic load(input logic [4:0] i, input logic [63:0] d);
        @(posedge pclk);
        load_valid <= 1'b1;
        load_idx <= i;
        load_data <= d;
        @(posedge pclk);
        load_valid <= 1'b0;
        load_data <= ~d;
    endtask

    // Hold the request until the edge that samples ready high
    task automatic issue(input iad_pkg::iad_op_e op, input logic cc, input logic imm,
            input logic [4:0] a, input logic [4:0] b, input logic [4:0] d,
            input logic [12:0] k13, input logic [21:0] k22);
        @(posedge pclk);
        issue_valid <= 1'b1;
        issue_op <= op;
        issue_set_cc <= cc;
        issue_use_imm <= imm;
        {src_a_reg, src_b_reg, dst_reg} <= {a, b, d};
        short_const_13 <= k13;
        set_const_22 <= k22;
        do
            @(posedge pclk);
        while (issue_ready !== 1'b1);
        issue_valid <= 1'b0;
        {src_a_reg, src_b_reg, short_const_13} <= ~{a, b, k13};
    endtask
endmodule // iad_decode_model

// [test/testbench.sv]
// Self-checking bench for the integer execute datapath
// Assumes iad_pkg and the decode stand-in are compiled first
`timescale 1ns/1ps
`include "iad_consts.svh"
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, issue_ready, issue_valid, issue_set_cc, issue_use_imm;
    logic [4:0] src_a_reg, src_b_reg, dst_reg, load_idx, result_dst;
    logic [12:0] short_const_13;
    logic [21:0] set_const_22, k22;
    logic load_valid, result_valid, divide_zero_trap, tag_overflow_trap;
    logic [63:0] load_data, result_data, ra, rb;
    logic [3:0] low_word_flags, full_width_flags;
    logic [70:0] exp_q[$];
    logic [70:0] e;
    iad_pkg::iad_op_e issue_op;
    int n_fail = 0;
    int checks = 0;
    int seed = 18017;

    // Clock at 50 MHz
    always #10 pclk = ~pclk;

    iad_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .issue_valid(issue_valid), .issue_ready(issue_ready),
        .issue_op(issue_op), .issue_set_cc(issue_set_cc), .issue_use_imm(issue_use_imm),
        .src_a_reg(src_a_reg), .src_b_reg(src_b_reg), .dst_reg(dst_reg),
        .short_const_13(short_const_13), .set_const_22(set_const_22),
        .load_valid(load_valid), .load_idx(load_idx), .load_data(load_data),
        .result_valid(result_valid), .result_data(result_data), .result_dst(result_dst),
        .divide_zero_trap(divide_zero_trap), .tag_overflow_trap(tag_overflow_trap),
        .low_word_flags(low_word_flags), .full_width_flags(full_width_flags));

    iad_decode_model model (.pclk(pclk), .issue_ready(issue_ready), .issue_op(issue_op),
        .issue_valid(issue_valid), .issue_set_cc(issue_set_cc),
        .issue_use_imm(issue_use_imm), .src_a_reg(src_a_reg), .src_b_reg(src_b_reg),
        .dst_reg(dst_reg), .short_const_13(short_const_13), .set_const_22(set_const_22),
        .load_valid(load_valid), .load_idx(load_idx), .load_data(load_data));

    //************************************************************
    // Shared tasks
    //************************************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] ex, input logic [63:0] got);
        checks++;
        if (got !== ex) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, ex, got);
        end
    endtask

    // Note the expected outcome, then hand the request to the model
    task automatic run(input iad_pkg::iad_op_e op, input logic cc, input logic imm,
            input logic [4:0] a, input logic [4:0] b, input logic [4:0] d,
            input logic [12:0] k13, input logic [1:0] kind, input logic [63:0] ex);
        exp_q.push_back({d, kind, ex});
        model.issue(op, cc, imm, a, b, d, k13, k22);
    endtask

    task automatic drain(input string name);
        for (int i = 0; i < 200 && exp_q.size() != 0; i++)
            @(posedge pclk);
        chk("pending results", 64'h0, 64'(exp_q.size()));
        $display("test %s done", name);
    endtask

    task automatic apb(input logic [11:0] a, output logic [31:0] q, output logic er);
        @(posedge pclk);
        {psel, penable, pwrite, paddr} <= {1'b1, 1'b0, 1'b0, a};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
    endtask

    // Result watcher: oldest note per result or trap pulse
    always @(posedge pclk) begin
        if (result_valid === 1'b1 || divide_zero_trap === 1'b1 || tag_overflow_trap === 1'b1) begin
            if (exp_q.size() == 0)
                chk("unexpected result", 64'h0, 64'h1);
            else begin
                e = exp_q.pop_front();
                chk("kind", 64'(e[65:64]), {62'h0, tag_overflow_trap, divide_zero_trap});
                if (e[65:64] == 2'h0) begin
                    chk("result", e[63:0], result_data);
                    chk("dest", 64'(e[70:66]), 64'(result_dst));
                end
            end
        end
    end

    //************************************************************
    // Tests
    //************************************************************
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        ra = {$random(seed), $random(seed)};
        rb = {$random(seed), $random(seed)};
        k22 = 22'($random(seed));
        model.load(5'h01, ra);
        model.load(5'h02, rb);
        model.load(5'h03, 64'h7);
        model.load(5'h04, 64'h8);
        model.load(5'h05, 64'h0);
        model.load(5'h07, 64'h7fff_ffff_ffff_fffc);
        model.load(5'h00, rb);
        run(iad_pkg::op_add, 0, 0, 1, 2, 8, 13'h0, 0, ra + rb);
        run(iad_pkg::op_add, 0, 1, 1, 2, 9, 13'h1ff0, 0, ra - 64'h10);
        run(iad_pkg::op_add, 0, 1, 0, 2, 24, 13'h1ff0, 0, 64'hffff_ffff_ffff_fff0);
        run(iad_pkg::op_add, 0, 0, 5, 2, 0, 13'h0, 0, rb);
        run(iad_pkg::op_add, 0, 0, 0, 0, 10, 13'h0, 0, 64'h0);
        run(iad_pkg::op_sub, 1, 0, 1, 1, 11, 13'h0, 0, 64'h0);
        run(iad_pkg::op_sub, 0, 0, 1, 2, 12, 13'h0, 0, ra - rb);
        run(iad_pkg::op_sll, 0, 1, 1, 2, 13, 13'h4, 0, ra << 4);
        run(iad_pkg::op_srl, 0, 0, 1, 4, 14, 13'h0, 0, ra >> 8);
        run(iad_pkg::set_high_constant_op, 0, 0, 1, 2, 15, 13'h0, 0, {32'h0, k22, 10'h0});
        drain("alu");
        chk("low flags", 64'h4, 64'(low_word_flags));
        chk("full flags", 64'h4, 64'(full_width_flags));
        run(iad_pkg::op_mulx, 0, 0, 1, 2, 16, 13'h0, 0, ra * rb);
        run(iad_pkg::op_udivx, 0, 0, 1, 4, 17, 13'h0, 0, ra / 64'h8);
        run(iad_pkg::op_umul, 0, 0, 1, 2, 18, 13'h0, 0, {32'h0, ra[31:0]} * {32'h0, rb[31:0]});
        run(iad_pkg::op_udiv, 0, 0, 1, 4, 19, 13'h0, 0, {32'h0, 32'(ra / 64'h8)});
        run(iad_pkg::op_udivx, 0, 0, 1, 5, 20, 13'h0, 1, 64'h0);
        drain("muldiv");
        run(iad_pkg::tagged_add_flags_op, 1, 0, 3, 4, 21, 13'h0, 0, 64'hf);
        drain("tag nonzero");
        chk("low flags", 64'h2, 64'(low_word_flags));
        chk("full flags", 64'h0, 64'(full_width_flags));
        run(iad_pkg::tagged_add_flags_op, 1, 0, 7, 4, 22, 13'h0, 0, 64'h8000_0000_0000_0004);
        drain("tag wide");
        chk("low flags", 64'h1, 64'(low_word_flags));
        chk("full flags", 64'ha, 64'(full_width_flags));
        run(iad_pkg::tagged_add_trapping_op, 1, 0, 3, 4, 23, 13'h0, 2, 64'h0);
        drain("tag trap");
        apb(`IAD_OFF_FLAGS, rd, err);
        chk("flags register", 64'ha1, 64'(rd[7:0]));
        apb(12'h010, rd, err);
        chk("unmapped error", 64'h1, 64'(err));
        $display("test apb done");
        close_out();
    end

    // Watchdog against a hang
    initial begin
        #100000;
        n_fail++;
        close_out();
    end
endmodule // testbench
